/* File: line_enable_pkg.sv */
// Purpose: Shared constants for the suspend and line enable block
// Assumes: 100 MHz system clock, 32-bit register bus with byte addresses
// Notes: Register offsets are byte addresses, one aligned word each
package line_enable_pkg;
	// ==========================================================
	// Clock and line rate
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned MAX_BAUD = 3000000;
	// Least divisor rounds up so the line never exceeds the rate limit
	localparam int unsigned MIN_DIV_INT = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
	localparam logic [15:0] MIN_DIV = 16'(MIN_DIV_INT);
	localparam logic [15:0] BAUD_DIV_RST = 16'h0364;
	localparam logic [3:0] LAST_BIT_IDX = 4'h8;
	localparam logic [3:0] FIRST_BIT_IDX = 4'h0;
	localparam logic [15:0] ONE_CYCLE = 16'h0001;

	// ==========================================================
	// Register map
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_PINSEL = 5'h04;
	localparam logic [4:0] OFS_BAUD = 5'h08;
	localparam logic [4:0] OFS_MAXPWR = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam int CTRL_PULLDOWN_BIT = 0;
	localparam int STAT_SUSPENDED_BIT = 0;
	localparam int STAT_PULLUP_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_HIGHPWR_BIT = 3;
	localparam int STAT_TE_BIT = 4;

	// ==========================================================
	// Power descriptor, milliamps
	localparam logic [15:0] MAXPWR_RST = 16'h005a;
	localparam logic [15:0] LOW_POWER_LIMIT = 16'h0064;
	localparam logic [15:0] HIGH_POWER_LIMIT = 16'h01f4;

	// ==========================================================
	// Pin functions and transmitter states
	typedef enum logic [1:0] {
		FN_LINE_DRIVE = 2'h0,
		FN_POWER_N = 2'h1,
		FN_SLEEP_N = 2'h2,
		FN_TRISTATE = 2'h3
	} pin_func_e;
	localparam pin_func_e PIN_TWO_RST = FN_LINE_DRIVE;
	localparam pin_func_e PIN_THREE_RST = FN_POWER_N;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LEAD = 2'b01,
		TX_DATA = 2'b11,
		TX_STOP = 2'b10
	} tx_state_e;
endpackage : line_enable_pkg

/* File: suspend_line_enable.sv */
// Purpose: Suspend, power and RS485 line enable outputs with a UART sender
// Assumes: All inputs synchronous to clk_sys; 8 data bits, 1 stop, no parity
// Notes: Registers reached over Avalon-MM, one wait state per access
//
// Functional notes
// - Line drive enable rises one bit period before the start bit.
// - Line drive enable drops as the stop bit of the last character begins.
// - Line drive enable is high only while a character is being sent.
// - By default pin two carries line drive enable, pin three power enable.
// - Low bus power sense forces suspend and leaves the D+ pull-up off.
// - During reset all UART pins are released to high impedance.
// - Active-low power enable is high in suspend and low while active.
// - Active-low sleep indicator is high while active, low in suspend.
// - The stored maximum bus current is reported; over 100 to 500 mA means high power.
// - The serial rate is clamped to at most 3 Mbaud.
// - With pull-down enabled, the UART transmit line is driven low throughout suspend.
`timescale 1ns/10ps
module suspend_line_enable (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic bus_power_sense,
	input wire logic usbSuspend,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady,
	output logic uartTxOut,
	output logic uartTxOe,
	output logic line_drive_enable,
	output logic power_enable_n,
	output logic sleepN,
	output logic dpPullupEnable,
	output logic [15:0] maxBusCurrent,
	output logic highPowerFunction,
	output logic configurable_io_pin_two_out,
	output logic configurable_io_pin_two_oe,
	output logic configurable_io_pin_three_out,
	output logic configurable_io_pin_three_oe
);
	// ==========================================================
	// Registers and state
	logic pulldownOnSuspend;
	line_enable_pkg::pin_func_e pinTwoFunc;
	line_enable_pkg::pin_func_e pinThreeFunc;
	logic [15:0] baudDiv;
	logic [15:0] maxPower;
	line_enable_pkg::tx_state_e txState;
	line_enable_pkg::tx_state_e next_txState;
	logic [15:0] bitCnt;
	logic [15:0] next_bitCnt;
	logic [3:0] bitIdx;
	logic [3:0] next_bitIdx;
	logic [8:0] shiftReg;
	logic [8:0] next_shiftReg;
	logic [7:0] holdData;
	logic holdFull;
	logic next_holdFull;
	logic lineBit;
	logic next_lineBit;
	logic teActive;
	logic next_teActive;

	// ==========================================================
	// Bus decode
	wire request = read | write;
	wire accept = request & ~waitrequest;
	wire wrAccept = accept & write;
	wire selCtrl = address == line_enable_pkg::OFS_CTRL;
	wire selPinsel = address == line_enable_pkg::OFS_PINSEL;
	wire selBaud = address == line_enable_pkg::OFS_BAUD;
	wire selMaxpwr = address == line_enable_pkg::OFS_MAXPWR;
	wire selStatus = address == line_enable_pkg::OFS_STATUS;
	wire [15:0] wrMask16 = {{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [15:0] baudWrite = (baudDiv & ~wrMask16) | (writedata[15:0] & wrMask16);
	wire [15:0] maxPwrWrite = (maxPower & ~wrMask16) | (writedata[15:0] & wrMask16);

	// ==========================================================
	// Power state
	wire suspended = ~bus_power_sense | usbSuspend;
	wire isHighPower = (maxPower > line_enable_pkg::LOW_POWER_LIMIT)
		&& (maxPower <= line_enable_pkg::HIGH_POWER_LIMIT);
	// Rate clamp: a too small divisor would overrun external drivers
	wire [15:0] effDiv = (baudDiv < line_enable_pkg::MIN_DIV) ?
		line_enable_pkg::MIN_DIV : baudDiv;
	wire [15:0] bitLoad = effDiv - line_enable_pkg::ONE_CYCLE;
	wire bitDone = bitCnt == 16'h0000;
	wire busy = txState != line_enable_pkg::TX_IDLE;
	wire txAccept = txValid & txReady & ~holdFull;

	wire [31:0] statusWord = {27'h0000000, teActive, isHighPower, busy,
		bus_power_sense, suspended};
	wire [31:0] readMux =
		selCtrl ? {31'h00000000, pulldownOnSuspend} :
		selPinsel ? {28'h0000000, pinThreeFunc, pinTwoFunc} :
		selBaud ? {16'h0000, baudDiv} :
		selMaxpwr ? {16'h0000, maxPower} :
		selStatus ? statusWord : 32'h00000000;

	// ==========================================================
	// Transmitter sequencing
	always_comb begin
		next_txState = txState;
		next_bitCnt = bitDone ? bitCnt : bitCnt - line_enable_pkg::ONE_CYCLE;
		next_bitIdx = bitIdx;
		next_shiftReg = shiftReg;
		next_holdFull = holdFull | txAccept;
		next_lineBit = lineBit;
		next_teActive = teActive;
		if (suspended) begin
			// Character in flight is dropped; enable must fall at once
			next_txState = line_enable_pkg::TX_IDLE;
			next_lineBit = 1'b1;
			next_teActive = 1'b0;
		end else begin
			unique case (txState)
				line_enable_pkg::TX_IDLE: begin
					next_lineBit = 1'b1;
					next_teActive = 1'b0;
					if (holdFull) begin
						next_shiftReg = {holdData, 1'b0};
						next_holdFull = txAccept;
						next_bitCnt = bitLoad;
						next_teActive = 1'b1;
						next_txState = line_enable_pkg::TX_LEAD;
					end
				end
				line_enable_pkg::TX_LEAD: begin
					if (bitDone) begin
						next_bitCnt = bitLoad;
						next_bitIdx = line_enable_pkg::FIRST_BIT_IDX;
						next_lineBit = shiftReg[0];
						next_shiftReg = {1'b1, shiftReg[8:1]};
						next_txState = line_enable_pkg::TX_DATA;
					end
				end
				line_enable_pkg::TX_DATA: begin
					if (bitDone) begin
						next_bitCnt = bitLoad;
						if (bitIdx == line_enable_pkg::LAST_BIT_IDX) begin
							next_lineBit = 1'b1;
							// Kept high only when another character follows
							next_teActive = holdFull;
							next_txState = line_enable_pkg::TX_STOP;
						end else begin
							next_bitIdx = bitIdx + 4'h1;
							next_lineBit = shiftReg[0];
							next_shiftReg = {1'b1, shiftReg[8:1]};
						end
					end
				end
				line_enable_pkg::TX_STOP: begin
					if (bitDone) begin
						next_bitCnt = bitLoad;
						if (holdFull) begin
							next_holdFull = txAccept;
							next_teActive = 1'b1;
							if (teActive) begin
								// Enable already up: start bit follows directly
								next_shiftReg = {1'b1, holdData};
								next_lineBit = 1'b0;
								next_bitIdx = line_enable_pkg::FIRST_BIT_IDX;
								next_txState = line_enable_pkg::TX_DATA;
							end else begin
								next_shiftReg = {holdData, 1'b0};
								next_txState = line_enable_pkg::TX_LEAD;
							end
						end else begin
							next_teActive = 1'b0;
							next_txState = line_enable_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Output selection for the configurable pins
	wire next_powerN = suspended;
	wire next_sleepN = ~suspended;
	wire next_pinTwo = (pinTwoFunc == line_enable_pkg::FN_LINE_DRIVE) ? next_teActive :
		(pinTwoFunc == line_enable_pkg::FN_POWER_N) ? next_powerN : next_sleepN;
	wire next_pinThree = (pinThreeFunc == line_enable_pkg::FN_LINE_DRIVE) ? next_teActive :
		(pinThreeFunc == line_enable_pkg::FN_POWER_N) ? next_powerN : next_sleepN;
	wire pullLow = suspended & pulldownOnSuspend;

	// ==========================================================
	// Bus slave
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			// One wait state: answer stands the cycle after the request rises
			waitrequest <= ~(request & waitrequest);
			readdata <= readMux;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pulldownOnSuspend <= 1'b0;
			pinTwoFunc <= line_enable_pkg::PIN_TWO_RST;
			pinThreeFunc <= line_enable_pkg::PIN_THREE_RST;
			baudDiv <= line_enable_pkg::BAUD_DIV_RST;
			maxPower <= line_enable_pkg::MAXPWR_RST;
		end else if (wrAccept) begin
			if (selCtrl && byteenable[0]) begin
				pulldownOnSuspend <= writedata[line_enable_pkg::CTRL_PULLDOWN_BIT];
			end
			if (selPinsel && byteenable[0]) begin
				pinTwoFunc <= line_enable_pkg::pin_func_e'(writedata[1:0]);
				pinThreeFunc <= line_enable_pkg::pin_func_e'(writedata[3:2]);
			end
			if (selBaud) begin
				baudDiv <= baudWrite;
			end
			if (selMaxpwr) begin
				maxPower <= maxPwrWrite;
			end
		end
	end

	// ==========================================================
	// Transmitter registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			txState <= line_enable_pkg::TX_IDLE;
			bitCnt <= 16'h0000;
			bitIdx <= 4'h0;
			shiftReg <= 9'h1ff;
			holdData <= 8'h00;
			holdFull <= 1'b0;
			lineBit <= 1'b1;
			teActive <= 1'b0;
			txReady <= 1'b0;
		end else begin
			txState <= next_txState;
			bitCnt <= next_bitCnt;
			bitIdx <= next_bitIdx;
			shiftReg <= next_shiftReg;
			holdData <= txAccept ? txData : holdData;
			holdFull <= next_holdFull;
			lineBit <= next_lineBit;
			teActive <= next_teActive;
			txReady <= ~next_holdFull & ~suspended;
		end
	end

	// ==========================================================
	// Pin and status outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			uartTxOut <= 1'b1;
			uartTxOe <= 1'b0;
			line_drive_enable <= 1'b0;
			power_enable_n <= 1'b1;
			sleepN <= 1'b0;
			dpPullupEnable <= 1'b0;
			maxBusCurrent <= line_enable_pkg::MAXPWR_RST;
			highPowerFunction <= 1'b0;
			configurable_io_pin_two_out <= 1'b0;
			configurable_io_pin_two_oe <= 1'b0;
			configurable_io_pin_three_out <= 1'b1;
			configurable_io_pin_three_oe <= 1'b0;
		end else begin
			uartTxOut <= pullLow ? 1'b0 : next_lineBit;
			uartTxOe <= 1'b1;
			line_drive_enable <= next_teActive;
			power_enable_n <= next_powerN;
			sleepN <= next_sleepN;
			dpPullupEnable <= bus_power_sense;
			maxBusCurrent <= maxPower;
			highPowerFunction <= isHighPower;
			configurable_io_pin_two_out <= next_pinTwo;
			configurable_io_pin_two_oe <= pinTwoFunc != line_enable_pkg::FN_TRISTATE;
			configurable_io_pin_three_out <= next_pinThree;
			configurable_io_pin_three_oe <= pinThreeFunc != line_enable_pkg::FN_TRISTATE;
		end
	end
endmodule : suspend_line_enable

/* File: line_enable_asserts.sv */
// Purpose: Port checks for the suspend and line enable block
// Assumes: Bound to suspend_line_enable, one clock domain
// Notes: Pull-down option is tracked from bus writes to CTRL
`timescale 1ns/10ps
module line_enable_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [4:0] address,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic bus_power_sense,
	input wire logic usbSuspend,
	input wire logic uartTxOut,
	input wire logic uartTxOe,
	input wire logic line_drive_enable,
	input wire logic power_enable_n,
	input wire logic sleepN,
	input wire logic dpPullupEnable,
	input wire logic [15:0] maxBusCurrent,
	input wire logic highPowerFunction,
	input wire logic configurable_io_pin_two_oe
);
	logic pullDown;
	logic [15:0] highCnt;
	wire susp = !bus_power_sense || usbSuspend;
	wire ctrlWr = write && !waitrequest && address == line_enable_pkg::OFS_CTRL;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Helpers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pullDown <= 1'b0;
		end else if (ctrlWr) begin
			pullDown <= writedata[line_enable_pkg::CTRL_PULLDOWN_BIT];
		end
	end
	// Counts the high time of the line while enabled, so the lead is measured
	always_ff @(posedge clk_sys) begin
		highCnt <= (line_drive_enable && uartTxOut) ? highCnt + 16'h0001 : 16'h0000;
	end
	// ==========================================================
	// Checks
	a_idle_in_suspend: assert property (susp [*2] |=> !line_drive_enable)
		else $error("line enable high in suspend");
	a_drop_at_stop: assert property ((!susp [*3]) ##0 $fell(line_drive_enable) |-> uartTxOut)
		else $error("line enable dropped outside stop bit");
	a_power_follows: assert property (1 |=> power_enable_n == $past(susp))
		else $error("power enable does not follow suspend");
	a_sleep_inverse: assert property (sleepN == !power_enable_n)
		else $error("sleep indicator not inverse of power enable");
	a_pullup_sense: assert property (1 |=> dpPullupEnable == $past(bus_power_sense))
		else $error("pull-up does not follow bus power");
	a_reset_release: assert property (@(posedge clk_sys) disable iff (1'b0)
		!rst_n && !$past(rst_n) |-> !uartTxOe && !configurable_io_pin_two_oe && !line_drive_enable)
		else $error("pins driven in reset");
	a_high_power: assert property (highPowerFunction == (maxBusCurrent > 16'h0064 &&
		maxBusCurrent <= 16'h01f4)) else $error("high power flag wrong");
	a_pull_down: assert property ((pullDown && susp) [*2] |=> !uartTxOut && uartTxOe)
		else $error("line not pulled low in suspend");
	a_lead_min: assert property ((!susp [*3]) ##0 ($fell(uartTxOut) && line_drive_enable)
		|-> highCnt >= line_enable_pkg::MIN_DIV) else $error("lead bit too short");
endmodule : line_enable_asserts
bind suspend_line_enable line_enable_asserts chk (.*);

/* File: line_partner.sv */
// Purpose: Far side model, line transceiver and switched power logic
// Assumes: Observes enable, transmit line and power enable only
// Notes: Drives nothing back, so no released lines to model
`timescale 1ns/10ps
module line_partner (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic line_drive_enable,
	input wire logic uartTxOut,
	input wire logic power_enable_n,
	output logic [15:0] leadCycles,
	output logic [15:0] bodyCycles,
	output logic [7:0] riseCount,
	output logic [7:0] wakeCount,
	output logic lowPower
);
	logic prevEn, prevPwr, inLead;
	logic [15:0] cnt;
	// ==========================================================
	// Switched logic sleeps while power enable is high
	assign lowPower = power_enable_n;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{prevEn, inLead, cnt, leadCycles, bodyCycles, riseCount, wakeCount} <= '0;
			prevPwr <= 1'b1;
		end else begin
			prevEn <= line_drive_enable;
			prevPwr <= power_enable_n;
			cnt <= cnt + 16'h0001;
			if (line_drive_enable && !prevEn) begin
				riseCount <= riseCount + 8'h01;
				cnt <= 16'h0001;
				inLead <= 1'b1;
			end else if (inLead && !uartTxOut) begin
				leadCycles <= cnt;
				cnt <= 16'h0001;
				inLead <= 1'b0;
			end
			if (!line_drive_enable && prevEn) bodyCycles <= cnt;
			// Own reset on power return, counted per wake
			if (prevPwr && !power_enable_n) wakeCount <= wakeCount + 8'h01;
		end
	end
endmodule : line_partner

/* File: tb.sv */
// Purpose: Self-checking bench for the suspend and line enable block
// Assumes: Divisor written below the limit, so frames use the clamp value
// Notes: Every wait is bounded and ends the run on a hang
`timescale 1ns/10ps
module tb;
	logic clk_sys = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, txValid = 1'b0;
	logic bus_power_sense = 1'b1, usbSuspend = 1'b0, waitrequest, txReady, uartTxOut;
	logic uartTxOe, line_drive_enable, power_enable_n, sleepN, dpPullupEnable, lowPower;
	logic highPowerFunction, configurable_io_pin_two_out, configurable_io_pin_two_oe;
	logic configurable_io_pin_three_out, configurable_io_pin_three_oe;
	logic [4:0] address = 5'h00;
	logic [3:0] byteenable = 4'hf;
	logic [7:0] txData = 8'h00, riseCount, wakeCount;
	logic [15:0] maxBusCurrent, leadCycles, bodyCycles;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [4:0] ofs [3] = '{5'h04, 5'h0c, 5'h14};
	logic [31:0] rv [3] = '{32'h4, 32'h5a, 32'h0};
	logic [1:0] pm [4] = '{2'b01, 2'b01, 2'b11, 2'b00};
	logic [15:0] mp [4] = '{16'h0064, 16'h0065, 16'h01f4, 16'h01f5};
	logic hp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	int miscompares = 0, total_checks = 0;
	localparam logic [31:0] D = 32'(line_enable_pkg::MIN_DIV);
	wire [3:0] pinView = {configurable_io_pin_two_out & configurable_io_pin_two_oe,
		configurable_io_pin_two_oe, configurable_io_pin_three_out & configurable_io_pin_three_oe,
		configurable_io_pin_three_oe};
	suspend_line_enable dut (.*);
	line_partner far (.*);
	always #5 clk_sys = ~clk_sys;
	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic hang(input string name);
		miscompares++;
		$display("[FAIL] %s expected answer seen none", name);
		final_report();
	endtask : hang
	// Starts one edge late so a release and a new request never share a step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0) break;
		end
		if (i == 50) hang("waitrequest");
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic send(input logic [7:0] c);
		int i;
		@(posedge clk_sys);
		txData <= c;
		txValid <= 1'b1;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk_sys);
			if (txReady === 1'b1) break;
		end
		if (i == 2000) hang("txReady");
		txValid <= 1'b0;
	endtask : send
	task automatic wait_enable(input logic lvl);
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk_sys);
			if (line_drive_enable === lvl) break;
		end
		if (i == 2000) hang("line_drive_enable");
	endtask : wait_enable
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle
	// ==========================================================
	// Sequence
	initial begin
		repeat (9) @(posedge clk_sys);
		#1;
		check("reset pins", 32'h0, {uartTxOe, pinView[2], pinView[0], line_drive_enable});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, ofs[k], 32'h0);
			check("reset read", rv[k], rd);
		end
		check("active", 32'h3, {power_enable_n, sleepN, dpPullupEnable});
		bus(1'b1, line_enable_pkg::OFS_BAUD, 32'h000a);
		send(8'ha5);
		wait_enable(1'b1);
		settle();
		check("pin two three", 32'hd, pinView);
		wait_enable(1'b0);
		settle();
		check("lead", D, {16'h0, leadCycles});
		check("frame", D * 32'h9, {16'h0, bodyCycles});
		send(8'h0f);
		send(8'hf0);
		wait_enable(1'b0);
		settle();
		check("rises", 32'h2, {24'h0, riseCount});
		// Two frames plus the shared stop bit; the second stop bit drops the enable
		check("pair frame", D * 32'h13, {16'h0, bodyCycles});
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, line_enable_pkg::OFS_PINSEL, 32'(c * 5));
			settle();
			check("pin mode", {28'h0, pm[c], pm[c]}, {28'h0, pinView});
		end
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, line_enable_pkg::OFS_MAXPWR, {16'h0, mp[k]});
			settle();
			check("max power", {mp[k], 15'h0, hp[k]}, {maxBusCurrent, 15'h0, highPowerFunction});
		end
		@(posedge clk_sys);
		bus_power_sense <= 1'b0;
		settle();
		check("suspend", 32'h9, {power_enable_n, sleepN, dpPullupEnable, lowPower});
		@(posedge clk_sys);
		bus_power_sense <= 1'b1;
		settle();
		check("wake", 32'h2, {24'h0, wakeCount});
		bus(1'b1, line_enable_pkg::OFS_CTRL, 32'h1);
		send(8'h55);
		wait_enable(1'b1);
		repeat (50) @(posedge clk_sys);
		usbSuspend <= 1'b1;
		settle();
		check("abort pulldown", 32'h1, {line_drive_enable, uartTxOut, uartTxOe});
		@(posedge clk_sys);
		usbSuspend <= 1'b0;
		settle();
		check("idle after", 32'h1, {line_drive_enable, uartTxOut});
		final_report();
	end
endmodule : tb
